// >>> verification/dcptu_pin_model.sv
// Far side model: external count source and the load on pin two
`timescale 1ns/1ns
`default_nettype none
module dcptu_pin_model (
   input  wire logic hclk,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   output logic      count_in,
   output logic      pin_level
);
   // An undriven pin floats up through the load's pull-up
   assign pin_level = pin_oe ? pin_out : 1'b1;

   initial count_in = 1'b0;

   // Slow pulses so each edge clears the input synchroniser
   task automatic pulse(input int n);
      repeat (n) begin
         repeat (4) @(posedge hclk);
         count_in <= 1'b1;
         repeat (4) @(posedge hclk);
         count_in <= 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// >>> verification/dcptu_top_test.sv
// Self-checking bench for the down counter pulse tone unit
`timescale 1ns/1ns
`default_nettype none
module dcptu_top_test;
   import dcptu_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        clk_en;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        ext_in;
   logic        gpio_out;
   logic        gpio_oe;
   logic        pin_out;
   logic        pin_oe;
   logic        tone_out;
   logic        irq;
   logic        pin_level;
   int          miscompares;
   int          samples_checked;

   dcptu_top dcptu_top_i (
      .hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .external_count_input(ext_in), .gpio_two_out(gpio_out), .gpio_two_oe(gpio_oe),
      .port_pin_two_out(pin_out), .port_pin_two_oe(pin_oe), .tone_out(tone_out), .irq(irq)
   );

   dcptu_pin_model dcptu_pin_model_i (
      .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .count_in(ext_in),
      .pin_level(pin_level)
   );

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end

   task automatic stop_test();
      $display("compares %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic check_in(input logic [31:0] got, input logic [31:0] lo,
                           input logic [31:0] hi);
      samples_checked++;
      if ((^got === 1'bx) || got < lo || got > hi) begin
         miscompares++;
         $display("BAD %0t got %h outside %h to %h", $time, got, lo, hi);
      end
   endtask

   // Single AHB-Lite word transfer; waits on hready in both phases
   task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d,
                      output logic [31:0] r);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {26'h0, idx, 2'b00};
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [31:0] r;
      bus(1'b1, idx, d, r);
   endtask

   task automatic rd_chk(input logic [3:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      bus(1'b0, idx, 8'h00, r);
      check(r, exp);
   endtask

   task automatic rd_in(input logic [3:0] idx, input logic [31:0] lo, input logic [31:0] hi);
      logic [31:0] r;
      bus(1'b0, idx, 8'h00, r);
      check_in(r, lo, hi);
   endtask

   task automatic settle();
      repeat (2) @(negedge hclk);
   endtask

   task automatic t_reset();
      check(hresp, 1'b0);
      rd_chk(DCPTU_IDX_VALUE, 32'h0);
      rd_chk(DCPTU_IDX_CTRL_A, 32'h0);
      rd_chk(DCPTU_IDX_CTRL_B, 32'h3f);
      rd_chk(DCPTU_IDX_DUTY, 32'h0);
      rd_chk(DCPTU_IDX_PRESCALE, 32'hff);
      rd_chk(DCPTU_IDX_INT_STATUS, 32'h0);
      rd_chk(DCPTU_IDX_INT_ENABLE, 32'h0);
      rd_chk(4'h9, 32'h0);
   endtask

   task automatic t_access();
      wr(DCPTU_IDX_PRESCALE, 8'h00);
      rd_chk(DCPTU_IDX_PRESCALE, 32'hff);
      wr(4'h9, 8'h5a);
      rd_chk(4'h9, 32'h0);
      wr(DCPTU_IDX_CTRL_A, 8'hc6);
      rd_chk(DCPTU_IDX_CTRL_A, 32'h06);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
      wr(DCPTU_IDX_CTRL_B, 8'h08);
      rd_chk(DCPTU_IDX_CTRL_B, 32'h08);
      wr(DCPTU_IDX_VALUE, 8'h5a);
      rd_chk(DCPTU_IDX_VALUE, 32'h5a);
      repeat (20) @(posedge hclk);
      rd_chk(DCPTU_IDX_VALUE, 32'h5a);
      rd_chk(DCPTU_IDX_INT_STATUS, 32'h0);
   endtask

   task automatic t_one_shot();
      wr(DCPTU_IDX_INT_ENABLE, 8'h01);
      wr(DCPTU_IDX_VALUE, 8'h05);
      wr(DCPTU_IDX_CTRL_A, 8'h05);
      repeat (20) @(posedge hclk);
      rd_chk(DCPTU_IDX_VALUE, 32'h0);
      rd_chk(DCPTU_IDX_INT_STATUS, 32'h1);
      check(irq, 1'b1);
      wr(DCPTU_IDX_INT_ENABLE, 8'h00);
      settle();
      check(irq, 1'b0);
      wr(DCPTU_IDX_INT_ENABLE, 8'h01);
      settle();
      check(irq, 1'b1);
      wr(DCPTU_IDX_INT_CLEAR, 8'h01);
      settle();
      check(irq, 1'b0);
      rd_chk(DCPTU_IDX_INT_STATUS, 32'h0);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
   endtask

   task automatic t_modes();
      wr(DCPTU_IDX_VALUE, 8'h02);
      wr(DCPTU_IDX_CTRL_A, 8'h01);
      repeat (10) @(posedge hclk);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
      rd_in(DCPTU_IDX_VALUE, 32'he8, 32'hfe);
      wr(DCPTU_IDX_VALUE, 8'h10);
      wr(DCPTU_IDX_CTRL_A, 8'h03);
      repeat (40) @(posedge hclk);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
      rd_in(DCPTU_IDX_VALUE, 32'h0, 32'h10);
      wr(DCPTU_IDX_INT_CLEAR, 8'h01);
   endtask

   task automatic t_prescaler();
      wr(DCPTU_IDX_CTRL_B, 8'h0f);
      wr(DCPTU_IDX_CTRL_B, 8'h07);
      wr(DCPTU_IDX_VALUE, 8'h05);
      wr(DCPTU_IDX_CTRL_A, 8'h01);
      repeat (60) @(posedge hclk);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
      rd_in(DCPTU_IDX_VALUE, 32'h04, 32'h05);
      rd_in(DCPTU_IDX_PRESCALE, 32'h90, 32'hf0);
      wr(DCPTU_IDX_CTRL_B, 8'h0f);
      wr(DCPTU_IDX_CTRL_B, 8'h08);
      wr(DCPTU_IDX_CTRL_B, 8'h00);
      wr(DCPTU_IDX_VALUE, 8'h20);
      wr(DCPTU_IDX_CTRL_A, 8'h01);
      repeat (20) @(posedge hclk);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
      rd_in(DCPTU_IDX_VALUE, 32'h12, 32'h17);
      wr(DCPTU_IDX_CTRL_B, 8'h08);
   endtask

   task automatic t_external();
      wr(DCPTU_IDX_CTRL_B, 8'h38);
      wr(DCPTU_IDX_VALUE, 8'h20);
      wr(DCPTU_IDX_CTRL_A, 8'h01);
      dcptu_pin_model_i.pulse(5);
      repeat (10) @(posedge hclk);
      rd_chk(DCPTU_IDX_VALUE, 32'h1b);
      wr(DCPTU_IDX_CTRL_B, 8'h28);
      dcptu_pin_model_i.pulse(3);
      repeat (10) @(posedge hclk);
      rd_chk(DCPTU_IDX_VALUE, 32'h18);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
      wr(DCPTU_IDX_CTRL_B, 8'h08);
   endtask

   // Counts cycles with the pin at the given level over a window of ten periods
   task automatic duty(input logic lvl);
      int n;
      n = 0;
      repeat (100) begin
         @(negedge hclk);
         if (pin_level === lvl) n++;
      end
      check_in(n, 45, 55);
   endtask

   task automatic t_pwm();
      gpio_oe <= 1'b1;
      settle();
      check(pin_level, 1'b0);
      gpio_oe <= 1'b0;
      settle();
      check(pin_level, 1'b1);
      wr(DCPTU_IDX_CTRL_A, 8'h80);
      settle();
      check(pin_level, 1'b0);
      wr(DCPTU_IDX_CTRL_A, 8'hc0);
      settle();
      check(pin_level, 1'b1);
      wr(DCPTU_IDX_DUTY, 8'h04);
      wr(DCPTU_IDX_VALUE, 8'h09);
      wr(DCPTU_IDX_CTRL_A, 8'h83);
      duty(1'b1);
      wr(DCPTU_IDX_CTRL_A, 8'hc3);
      duty(1'b0);
      wr(DCPTU_IDX_CTRL_A, 8'h00);
   endtask

   task automatic tone(input logic [7:0] code, input int lo, input int hi);
      int   n;
      logic prev;
      n = 0;
      wr(DCPTU_IDX_TONE, code);
      settle();
      prev = tone_out;
      repeat (20) begin
         @(negedge hclk);
         if (tone_out !== prev) n++;
         prev = tone_out;
      end
      check_in(n, lo, hi);
   endtask

   task automatic t_tone();
      logic prev;
      wr(DCPTU_IDX_VALUE, 8'h00);
      wr(DCPTU_IDX_CTRL_A, 8'h01);
      tone(8'h08, 0, 0);
      tone(8'h88, 17, 20);
      tone(8'h89, 8, 11);
      // Prescaler running at ratio 0 so its low count bits toggle
      wr(DCPTU_IDX_CTRL_B, 8'h00);
      tone(8'h80, 17, 20);
      tone(8'h81, 8, 11);
      wr(DCPTU_IDX_CTRL_B, 8'h08);
      wr(DCPTU_IDX_TONE, 8'h88);
      // Frozen block: a tone that toggles every cycle must hold still
      clk_en <= 1'b0;
      settle();
      check(hreadyout, 1'b0);
      prev = tone_out;
      repeat (5) @(negedge hclk);
      check(tone_out, prev);
      @(posedge hclk);
      clk_en <= 1'b1;
      wr(DCPTU_IDX_CTRL_A, 8'h00);
   endtask

   // A full run needs well under two thousand cycles
   initial begin
      #100000;
      miscompares++;
      stop_test();
   end

   initial begin
      miscompares = 0;
      samples_checked = 0;
      hresetn = 1'b0;
      clk_en = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      gpio_out = 1'b0;
      gpio_oe = 1'b0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset();
      t_access();
      t_one_shot();
      t_modes();
      t_prescaler();
      t_external();
      t_pwm();
      t_tone();
      stop_test();
   end
endmodule
`default_nettype wire

// >>> verilog/dcptu_pkg.sv
// Register map, field layout and reset values of the down counter pulse tone unit
package dcptu_pkg;
   // Register indices; byte address is four times the index
   localparam logic [3:0] DCPTU_IDX_VALUE      = 4'h0;
   localparam logic [3:0] DCPTU_IDX_CTRL_A     = 4'h1;
   localparam logic [3:0] DCPTU_IDX_CTRL_B     = 4'h2;
   localparam logic [3:0] DCPTU_IDX_DUTY       = 4'h3;
   localparam logic [3:0] DCPTU_IDX_PRESCALE   = 4'h4;
   localparam logic [3:0] DCPTU_IDX_TONE       = 4'h5;
   localparam logic [3:0] DCPTU_IDX_INT_STATUS = 4'h6;
   localparam logic [3:0] DCPTU_IDX_INT_CLEAR  = 4'h7;
   localparam logic [3:0] DCPTU_IDX_INT_ENABLE = 4'h8;

   // down_counter_control_a fields
   localparam int DCPTU_CA_EN_BIT   = 0;
   localparam int DCPTU_CA_RL_BIT   = 1;
   localparam int DCPTU_CA_OS_BIT   = 2;
   localparam int DCPTU_CA_PAL_BIT  = 6;
   localparam int DCPTU_CA_POE_BIT  = 7;
   // down_counter_control_b fields
   localparam int DCPTU_CB_RATIO_LSB = 0;
   localparam int DCPTU_CB_DIS_BIT   = 3;
   localparam int DCPTU_CB_EDGE_BIT  = 4;
   localparam int DCPTU_CB_SRC_BIT   = 5;
   // tone_output_control fields
   localparam int DCPTU_TONE_SEL_LSB = 0;
   localparam int DCPTU_TONE_EN_BIT  = 7;
   // Interrupt status, clear and enable layout
   localparam int DCPTU_INT_UF_BIT   = 0;

   // Reset values
   localparam logic [7:0] DCPTU_VALUE_RESET    = 8'h00;
   localparam logic [7:0] DCPTU_CTRL_A_RESET   = 8'h00;
   localparam logic [7:0] DCPTU_CTRL_B_RESET   = 8'h3f;
   localparam logic [7:0] DCPTU_DUTY_RESET     = 8'h00;
   localparam logic [7:0] DCPTU_PRESCALE_RESET = 8'hff;
   localparam logic [7:0] DCPTU_TONE_RESET     = 8'h0f;
   localparam logic [7:0] DCPTU_UNDERFLOW_LOAD = 8'hff;
endpackage

// >>> verilog/dcptu_pre_if.sv
// Link between the down counter and its prescaler
`timescale 1ns/1ns
`default_nettype none
interface dcptu_pre_if;
   logic       src_tick;
   logic [2:0] ratio;
   logic       disable_n;
   logic       out_tick;
   logic [7:0] count;

   modport ctl (output src_tick, output ratio, output disable_n, input out_tick, input count);
   modport pre (input src_tick, input ratio, input disable_n, output out_tick, output count);
endinterface
`default_nettype wire

// >>> verilog/dcptu_prescaler.sv
// Second prescaler: 8-bit down counter dividing the count clock by a power of two
`timescale 1ns/1ns
`default_nettype none
module dcptu_prescaler
   import dcptu_pkg::*;
(
   input  wire logic hclk,
   input  wire logic hresetn,
   dcptu_pre_if.pre  pi
);
   logic [7:0] count_q;
   logic [7:0] mask;

   // Ratio n divides by 2**(n+1): low n+1 bits all zero once per period
   assign mask = 8'((16'h0002 << pi.ratio) - 16'h0001);
   assign pi.count = count_q;
   assign pi.out_tick = pi.disable_n ? pi.src_tick
                                     : (pi.src_tick && ((count_q & mask) == 8'h00));

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_q <= DCPTU_PRESCALE_RESET;
      end else if (pi.src_tick && !pi.disable_n) begin
         count_q <= count_q - 8'h01;
      end
   end

   property p_divide_min_two;
      @(posedge hclk) disable iff (!hresetn)
      (pi.out_tick && !pi.disable_n) ##1 ($stable(pi.ratio) && !pi.disable_n) |-> !pi.out_tick;
   endproperty
   a_divide_min_two: assert property (p_divide_min_two) else $error("prescaler ticked twice in a row");

   property p_bypass;
      @(posedge hclk) disable iff (!hresetn)
      (pi.disable_n && pi.src_tick) |=> $stable(count_q);
   endproperty
   a_bypass: assert property (p_bypass) else $error("bypassed prescaler kept counting");
endmodule
`default_nettype wire

// >>> verilog/dcptu_top.sv
// Down counter with prescaler, pulse output, tone output and AHB-Lite registers
// Behaviour
// - Counter register read returns live count
// - Counter write loads reload and count
// - Non-stop, no reload: underflow loads 0xff
// - Non-stop with reload: underflow loads reload
// - One-shot: stop after reaching 0x00 underflow
// - Polarity bit set makes pulse active low
// - Pulse enable puts pulse on pin two
// - Pulse active from duty match until underflow
// - Reload sets period, duty sets width
// - Prescaler divides by 2**(ratio+1), bypassable
// - External edge bit picks falling or rising
// - Source bit picks external pin or clock
// - Prescaler register read returns prescaler count
// - Tone selects prescaler or counter bit, gated
// - Underflow sets sticky flag until cleared
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module dcptu_top
   import dcptu_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        clk_en,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   input  wire logic        external_count_input,
   input  wire logic        gpio_two_out,
   input  wire logic        gpio_two_oe,
   output logic             port_pin_two_out,
   output logic             port_pin_two_oe,
   output logic             tone_out,
   output logic             irq
);
   dcptu_pre_if pi ();

   // Bus state
   logic       wr_q;
   logic [3:0] idx_q;
   logic       hit_q;
   logic [7:0] rd_q;
   logic [7:0] rd_mux;
   logic       take;
   logic       addr_hit;
   logic       wr_now;
   logic       wr_value;
   logic       wr_ctrl_a;

   // Control fields
   logic       en_q;
   logic       rl_q;
   logic       os_q;
   logic       pal_q;
   logic       poe_q;
   logic [2:0] ratio_q;
   logic       pdis_q;
   logic       edge_q;
   logic       src_q;
   logic       tone_en_q;
   logic [3:0] tone_sel_q;
   logic [7:0] duty_q;
   logic [7:0] reload_q;
   logic       ien_q;

   // Counter state
   logic [7:0] cnt_q;
   logic       stop_q;
   logic       act_q;
   logic       flag_q;
   logic       en_rise;
   logic       tick;
   logic       uf;

   // External input synchroniser and edge detect
   logic       ext_s1_q;
   logic       ext_s2_q;
   logic       ext_s3_q;
   logic       ext_edge;

   logic       pin_out_q;
   logic       pin_oe_q;
   logic       tone_q;
   logic       tone_src;

   // Bus frozen with the rest of the block: the slave stalls while clk_en is low
   assign hreadyout = clk_en;
   assign hresp     = 1'b0;
   assign hrdata    = {24'h000000, rd_q};

   assign take     = hsel && hready && htrans[1] && clk_en;
   assign addr_hit = (haddr[31:6] == 26'h0) && (haddr[5:2] <= DCPTU_IDX_INT_ENABLE);
   assign wr_now   = wr_q && hit_q && clk_en;
   assign wr_value = wr_now && (idx_q == DCPTU_IDX_VALUE);
   assign wr_ctrl_a = wr_now && (idx_q == DCPTU_IDX_CTRL_A);
   assign en_rise  = wr_ctrl_a && !en_q && hwdata[DCPTU_CA_EN_BIT];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= 1'b0;
         idx_q <= 4'h0;
         hit_q <= 1'b0;
      end else if (clk_en) begin
         wr_q  <= take && hwrite;
         idx_q <= haddr[5:2];
         hit_q <= take && addr_hit;
      end
   end

   // Read data registered at the address phase; write-only fields read as zero
   always_comb begin
      rd_mux = 8'h00;
      if (addr_hit) begin
         unique case (haddr[5:2])
            DCPTU_IDX_VALUE:      rd_mux = cnt_q;
            DCPTU_IDX_CTRL_A:     rd_mux = {5'h00, os_q, rl_q, en_q};
            DCPTU_IDX_CTRL_B:     rd_mux = {2'h0, src_q, edge_q, pdis_q, ratio_q};
            DCPTU_IDX_PRESCALE:   rd_mux = pi.count;
            DCPTU_IDX_INT_STATUS: rd_mux = {7'h00, flag_q};
            DCPTU_IDX_INT_ENABLE: rd_mux = {7'h00, ien_q};
            default:              rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= 8'h00;
      end else if (take && !hwrite) begin
         rd_q <= rd_mux;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {poe_q, pal_q} <= {DCPTU_CTRL_A_RESET[DCPTU_CA_POE_BIT],
                            DCPTU_CTRL_A_RESET[DCPTU_CA_PAL_BIT]};
         {os_q, rl_q, en_q} <= DCPTU_CTRL_A_RESET[2:0];
      end else if (wr_ctrl_a) begin
         poe_q <= hwdata[DCPTU_CA_POE_BIT];
         pal_q <= hwdata[DCPTU_CA_PAL_BIT];
         os_q  <= hwdata[DCPTU_CA_OS_BIT];
         rl_q  <= hwdata[DCPTU_CA_RL_BIT];
         en_q  <= hwdata[DCPTU_CA_EN_BIT];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {src_q, edge_q, pdis_q, ratio_q} <= DCPTU_CTRL_B_RESET[5:0];
      end else if (wr_now && (idx_q == DCPTU_IDX_CTRL_B)) begin
         src_q   <= hwdata[DCPTU_CB_SRC_BIT];
         edge_q  <= hwdata[DCPTU_CB_EDGE_BIT];
         pdis_q  <= hwdata[DCPTU_CB_DIS_BIT];
         ratio_q <= hwdata[DCPTU_CB_RATIO_LSB +: 3];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         duty_q <= DCPTU_DUTY_RESET;
      end else if (wr_now && (idx_q == DCPTU_IDX_DUTY)) begin
         duty_q <= hwdata[7:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_en_q  <= DCPTU_TONE_RESET[DCPTU_TONE_EN_BIT];
         tone_sel_q <= DCPTU_TONE_RESET[DCPTU_TONE_SEL_LSB +: 4];
      end else if (wr_now && (idx_q == DCPTU_IDX_TONE)) begin
         tone_en_q  <= hwdata[DCPTU_TONE_EN_BIT];
         tone_sel_q <= hwdata[DCPTU_TONE_SEL_LSB +: 4];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ien_q <= 1'b0;
      end else if (wr_now && (idx_q == DCPTU_IDX_INT_ENABLE)) begin
         ien_q <= hwdata[DCPTU_INT_UF_BIT];
      end
   end

   // Pin input: two flops before use, third flop only for the edge compare
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
      end else if (clk_en) begin
         ext_s1_q <= external_count_input;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
      end
   end

   assign ext_edge = edge_q ? (ext_s3_q && !ext_s2_q) : (!ext_s3_q && ext_s2_q);

   // The prescaler only advances while the counter runs
   assign pi.src_tick  = clk_en && en_q && !stop_q && (src_q ? ext_edge : 1'b1);
   assign pi.ratio     = ratio_q;
   assign pi.disable_n = pdis_q;

   dcptu_prescaler dcptu_prescaler_i (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pi      (pi)
   );

   assign tick = pi.out_tick;
   assign uf   = tick && (cnt_q == 8'h00);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q    <= DCPTU_VALUE_RESET;
         reload_q <= DCPTU_VALUE_RESET;
      end else if (wr_value) begin
         cnt_q    <= hwdata[7:0];
         reload_q <= hwdata[7:0];
      end else if (uf) begin
         if (os_q) begin
            cnt_q <= 8'h00;
         end else if (rl_q) begin
            cnt_q <= reload_q;
         end else begin
            cnt_q <= DCPTU_UNDERFLOW_LOAD;
         end
      end else if (tick) begin
         cnt_q <= cnt_q - 8'h01;
      end
   end

   // A one-shot run ends at underflow; a new load or enable restarts it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stop_q <= 1'b0;
      end else if (wr_value || en_rise) begin
         stop_q <= 1'b0;
      end else if (uf && os_q) begin
         stop_q <= 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         act_q <= 1'b0;
      end else if (wr_value || en_rise || uf) begin
         act_q <= 1'b0;
      end else if (tick && ((cnt_q - 8'h01) == duty_q)) begin
         act_q <= 1'b1;
      end
   end

   // Set wins over a clear written in the same cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_q <= 1'b0;
      end else if (uf) begin
         flag_q <= 1'b1;
      end else if (wr_now && (idx_q == DCPTU_IDX_INT_CLEAR) && hwdata[DCPTU_INT_UF_BIT]) begin
         flag_q <= 1'b0;
      end
   end

   assign irq = flag_q && ien_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out_q <= 1'b0;
         pin_oe_q  <= 1'b0;
      end else if (clk_en) begin
         pin_out_q <= poe_q ? (act_q ^ pal_q) : gpio_two_out;
         pin_oe_q  <= poe_q ? 1'b1 : gpio_two_oe;
      end
   end

   assign port_pin_two_out = pin_out_q;
   assign port_pin_two_oe  = pin_oe_q;

   // Prescaler bit k toggles at source/2**(k+1); codes 1000 up take counter bits 0 to 7
   assign tone_src = tone_sel_q[3] ? cnt_q[tone_sel_q[2:0]] : pi.count[tone_sel_q[2:0]];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tone_q <= 1'b0;
      end else if (clk_en) begin
         tone_q <= tone_en_q && tone_src;
      end
   end

   assign tone_out = tone_q;

   property p_read_count;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && (haddr == {26'h0, DCPTU_IDX_VALUE, 2'b00})) |=>
         (hrdata == {24'h0, $past(cnt_q)});
   endproperty
   a_read_count: assert property (p_read_count) else $error("count read mismatch");

   property p_write_count;
      @(posedge hclk) disable iff (!hresetn)
      wr_value |=> (cnt_q == $past(hwdata[7:0])) && (reload_q == $past(hwdata[7:0]));
   endproperty
   a_write_count: assert property (p_write_count) else $error("count write not loaded");

   property p_uf_ff;
      @(posedge hclk) disable iff (!hresetn)
      (uf && !os_q && !rl_q && !wr_value) |=> (cnt_q == 8'hff) && flag_q;
   endproperty
   a_uf_ff: assert property (p_uf_ff) else $error("underflow did not load 0xff");

   property p_uf_reload;
      @(posedge hclk) disable iff (!hresetn)
      (uf && !os_q && rl_q && !wr_value) |=> (cnt_q == $past(reload_q));
   endproperty
   a_uf_reload: assert property (p_uf_reload) else $error("underflow did not reload");

   property p_one_shot;
      @(posedge hclk) disable iff (!hresetn)
      (uf && os_q && !wr_value && !en_rise) |=> stop_q && (cnt_q == 8'h00) ##1 (cnt_q == 8'h00);
   endproperty
   a_one_shot: assert property (p_one_shot) else $error("one-shot kept counting");

   property p_polarity;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && poe_q && pal_q) |=> (port_pin_two_out == !$past(act_q));
   endproperty
   a_polarity: assert property (p_polarity) else $error("active-low pulse wrong level");

   property p_pin_drive;
      @(posedge hclk) disable iff (!hresetn)
      (clk_en && !poe_q) |=> (port_pin_two_oe == $past(gpio_two_oe))
                              && (port_pin_two_out == $past(gpio_two_out));
   endproperty
   a_pin_drive: assert property (p_pin_drive) else $error("pin two not general purpose");

   property p_pulse_end;
      @(posedge hclk) disable iff (!hresetn)
      (tick && (cnt_q == 8'h01) && (duty_q == 8'h00) && !wr_value && !en_rise) |=>
         act_q ##[1:600] (!act_q || !en_q || wr_value);
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse did not start on duty match");

   property p_read_prescale;
      @(posedge hclk) disable iff (!hresetn)
      (take && !hwrite && (haddr == {26'h0, DCPTU_IDX_PRESCALE, 2'b00})) |=>
         (hrdata[7:0] == $past(pi.count));
   endproperty
   a_read_prescale: assert property (p_read_prescale) else $error("prescaler read mismatch");

   property p_hold_disabled;
      @(posedge hclk) disable iff (!hresetn)
      (!en_q && !wr_value) |=> $stable(cnt_q) && !$rose(act_q) && !$rose(flag_q);
   endproperty
   a_hold_disabled: assert property (p_hold_disabled) else $error("disabled counter moved");

   property p_flag_sticky;
      @(posedge hclk) disable iff (!hresetn)
      flag_q && !(wr_now && (idx_q == DCPTU_IDX_INT_CLEAR) && hwdata[DCPTU_INT_UF_BIT])
         |=> flag_q;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost without clear");
endmodule
`default_nettype wire
